/* File: indexed_draw_vertex_fetch.sv */
// Draw command sequencer: index and parameter fetch, vertex emission
// Functional notes
// R1: Indexed draw emits exactly index_total fetched vertices
// R2: Index buffer is packed unsigned array
// R3: First index at slot*width plus bind offset
// R4: Following indices from consecutive element positions
// R5: Restart compare on raw native-width index
// R6: Narrow index zero-extended to 32 bits
// R7: Signed bias added gives emitted vertex number
// R8: Repeat per instance, instance number counts up
// R9: Current topology travels with each vertex
// R10: Source keeps index range inside buffer
// R11: Source draws only inside render pass
// R12: Indirect parameters read from memory at execution
// R13: Indirect: draw_total records, offset then stride
// R14: Zero draw_total: no draws, no fetches
// R15: Stride ignored when draw_total below two
// R16: Each record is one fixed-layout array element
// R17: Width code 0 narrow 16, 1 wide 32
// R18: Non-indexed: consecutive numbers from base vertex
// R19: Lower instances first, lower addresses first
// R20: Record words: vertex, instance, base vertex, base instance
// R21: Vertex output valid/ready, stable until taken
// R22: Restart-matching index flagged to assembler
`timescale 1ns/100ps
module indexed_draw_vertex_fetch
  import draw_fetch_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_bind_valid,
  input wire logic [ADDR_W-1:0] i_bind_offset,
  input wire logic i_bind_width_select,
  input wire logic i_cmd_valid,
  output logic o_cmd_ready,
  input wire draw_fetch_pkg::draw_kind_t i_cmd_kind,
  input wire logic [draw_fetch_pkg::TOPO_W-1:0] i_cmd_topology,
  input wire logic i_cmd_restart_enable,
  input wire logic [31:0] i_cmd_vertex_total,
  input wire logic [31:0] i_cmd_instance_total,
  input wire logic [31:0] i_cmd_start_slot,
  input wire logic [31:0] i_cmd_base_vertex_number,
  input wire logic [31:0] i_cmd_index_bias,
  input wire logic [31:0] i_cmd_base_instance_id,
  input wire logic [ADDR_W-1:0] i_cmd_param_offset,
  input wire logic [31:0] i_cmd_draw_total,
  input wire logic [ADDR_W-1:0] i_cmd_stride,
  output logic o_cmd_done,
  output logic o_mem_req_valid,
  input wire logic i_mem_req_ready,
  output logic [ADDR_W-1:0] o_mem_addr,
  input wire logic i_mem_rsp_valid,
  input wire logic [31:0] i_mem_rsp_data,
  output logic o_vtx_valid,
  input wire logic i_vtx_ready,
  output logic [31:0] o_emitted_vertex_number,
  output logic [31:0] o_emitted_instance_number,
  output logic o_restart,
  output logic [draw_fetch_pkg::TOPO_W-1:0] o_topology
);
  import draw_fetch_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Byte address of an index element
  function automatic logic [ADDR_W-1:0] index_address(input logic [ADDR_W-1:0] base, input logic [31:0] slot,
    input logic wide);
    logic [ADDR_W-1:0] elem;
    elem = ADDR_W'(slot);
    return base + (elem << (wide ? WIDE_SHIFT : NARROW_SHIFT));
  endfunction : index_address
  // Byte address of one word inside a parameter record
  function automatic logic [ADDR_W-1:0] record_word_addr(input logic [ADDR_W-1:0] base, input logic [1:0] word);
    return base + ADDR_W'({word, 2'b00});
  endfunction : record_word_addr
  // ----------------------------------------
  // State
  // ----------------------------------------
  fetch_state_t state, next_state;
  logic [ADDR_W-1:0] idx_base;
  logic idx_wide;
  draw_kind_t kind, next_kind;
  logic [TOPO_W-1:0] topology, next_topology;
  logic restart_en, next_restart_en;
  logic [31:0] vertex_total, next_vertex_total;
  logic [31:0] instance_total, next_instance_total;
  logic [31:0] first, next_first;
  logic [31:0] bias, next_bias;
  logic [31:0] base_instance, next_base_instance;
  logic [31:0] vtx_pos, next_vtx_pos;
  logic [31:0] inst_pos, next_inst_pos;
  logic [31:0] cur_instance, next_cur_instance;
  logic [31:0] draws_left, next_draws_left;
  logic [ADDR_W-1:0] record_addr, next_record_addr;
  logic [ADDR_W-1:0] stride, next_stride;
  logic [1:0] word_sel, next_word_sel;
  logic [ADDR_W-1:0] next_mem_addr;
  logic [31:0] next_vertex, next_instance;
  logic next_restart, next_done;
  // ----------------------------------------
  // Decoding
  // ----------------------------------------
  wire logic cmd_take = i_cmd_valid && o_cmd_ready;
  wire logic mem_fire = o_mem_req_valid && i_mem_req_ready;
  wire logic vtx_fire = o_vtx_valid && i_vtx_ready;
  wire logic indexed = (kind == KIND_INDEXED);
  wire logic indirect = (kind == KIND_INDIRECT);
  wire logic [31:0] vtx_pos_inc = vtx_pos + ONE_WORD;
  wire logic [31:0] inst_pos_inc = inst_pos + ONE_WORD;
  wire logic last_vertex = (vtx_pos_inc == vertex_total);
  wire logic last_instance = (inst_pos_inc == instance_total);
  wire logic [1:0] word_inc = word_sel + 2'h1;
  // Slot advances by element, never by byte, so no gaps
  wire logic [31:0] slot = first + vtx_pos; // R4
  wire logic [ADDR_W-1:0] idx_addr = index_address(idx_base, slot, idx_wide); // R3
  // Narrow element sits in the half picked by address bit 1
  wire logic [15:0] half = o_mem_addr[1] ? i_mem_rsp_data[31:16] : i_mem_rsp_data[15:0]; // R2
  // Compare before extension so a narrow all-ones is caught
  wire logic hit_narrow = (half == NARROW_RESTART); // R5
  wire logic hit_wide = (i_mem_rsp_data == WIDE_RESTART); // R5
  wire logic restart_hit = restart_en && (idx_wide ? hit_wide : hit_narrow); // R22
  wire logic [31:0] index_ext = idx_wide ? i_mem_rsp_data : {16'h0000, half}; // R6
  wire logic [31:0] index_vertex = index_ext + bias; // R7
  wire logic [ADDR_W-1:0] next_record = record_addr + stride; // R13
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_topology = topology;
    next_restart_en = restart_en;
    next_vertex_total = vertex_total;
    next_instance_total = instance_total;
    next_first = first;
    next_bias = bias;
    next_base_instance = base_instance;
    next_vtx_pos = vtx_pos;
    next_inst_pos = inst_pos;
    next_cur_instance = cur_instance;
    next_draws_left = draws_left;
    next_record_addr = record_addr;
    next_stride = stride;
    next_word_sel = word_sel;
    next_mem_addr = o_mem_addr;
    next_vertex = o_emitted_vertex_number;
    next_instance = o_emitted_instance_number;
    next_restart = o_restart;
    next_done = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (cmd_take) begin
          next_kind = i_cmd_kind;
          next_topology = i_cmd_topology; // R9
          next_restart_en = i_cmd_restart_enable;
          next_vertex_total = i_cmd_vertex_total;
          next_instance_total = i_cmd_instance_total;
          next_bias = i_cmd_index_bias;
          next_base_instance = i_cmd_base_instance_id;
          next_first = (i_cmd_kind == KIND_INDEXED) ? i_cmd_start_slot : i_cmd_base_vertex_number;
          next_draws_left = i_cmd_draw_total;
          next_record_addr = i_cmd_param_offset; // R13
          next_stride = i_cmd_stride;
          next_word_sel = REC_VERTEX_TOTAL;
          // Empty commands still pass ST_END, so ready drops for one cycle (two for direct or indexed, via ST_START) before done
          if (i_cmd_kind == KIND_INDIRECT && i_cmd_draw_total != WORD_RESET) begin
            next_mem_addr = i_cmd_param_offset; // R12
            next_state = ST_PARAM_REQ;
          end else if (i_cmd_kind == KIND_INDIRECT || i_cmd_kind == KIND_UNUSED) begin
            next_state = ST_END; // R14
          end else begin
            next_state = ST_START;
          end
        end
      end
      ST_PARAM_REQ: begin
        next_state = mem_fire ? ST_PARAM_WAIT : ST_PARAM_REQ;
      end
      ST_PARAM_WAIT: begin
        if (i_mem_rsp_valid) begin
          // Fixed four-word record, filled in word order
          unique case (word_sel)
            REC_VERTEX_TOTAL: next_vertex_total = i_mem_rsp_data; // R20
            REC_INSTANCE_TOTAL: next_instance_total = i_mem_rsp_data; // R20
            REC_BASE_VERTEX: next_first = i_mem_rsp_data; // R20
            REC_BASE_INSTANCE: next_base_instance = i_mem_rsp_data; // R20
          endcase
          if (word_sel == REC_LAST_WORD) begin
            next_state = ST_START; // R16
          end else begin
            next_word_sel = word_inc;
            next_mem_addr = record_word_addr(record_addr, word_inc);
            next_state = ST_PARAM_REQ;
          end
        end
      end
      ST_START: begin
        next_vtx_pos = WORD_RESET;
        next_inst_pos = WORD_RESET;
        next_cur_instance = base_instance; // R8
        next_state = (vertex_total == WORD_RESET || instance_total == WORD_RESET) ? ST_END : ST_VTX;
      end
      ST_VTX: begin
        next_instance = cur_instance;
        if (indexed) begin
          next_mem_addr = idx_addr; // R1
          next_state = ST_IDX_REQ;
        end else begin
          next_vertex = slot; // R18
          next_restart = 1'b0;
          next_state = ST_EMIT;
        end
      end
      ST_IDX_REQ: begin
        next_state = mem_fire ? ST_IDX_WAIT : ST_IDX_REQ;
      end
      ST_IDX_WAIT: begin
        if (i_mem_rsp_valid) begin
          next_vertex = index_vertex; // R7
          next_restart = restart_hit; // R22
          next_state = ST_EMIT;
        end
      end
      ST_EMIT: begin
        // Output holds until taken; all of one instance before the next
        if (vtx_fire) begin // R21
          if (last_vertex) begin
            next_vtx_pos = WORD_RESET;
            if (last_instance) begin
              next_state = ST_END;
            end else begin
              next_inst_pos = inst_pos_inc; // R19
              next_cur_instance = cur_instance + ONE_WORD; // R8
              next_state = ST_VTX;
            end
          end else begin
            next_vtx_pos = vtx_pos_inc; // R19
            next_state = ST_VTX;
          end
        end
      end
      ST_END: begin
        // Stride only read when another record follows
        if (indirect && draws_left > ONE_WORD) begin // R15
          next_draws_left = draws_left - ONE_WORD;
          next_record_addr = next_record; // R13
          next_word_sel = REC_VERTEX_TOTAL;
          next_mem_addr = next_record;
          next_state = ST_PARAM_REQ;
        end else begin
          next_done = 1'b1;
          next_state = ST_IDLE;
        end
      end
    endcase
  end
  // ----------------------------------------
  // Registered outputs follow the next state
  // ----------------------------------------
  wire logic next_req = (next_state == ST_PARAM_REQ) || (next_state == ST_IDX_REQ);
  wire logic next_valid = (next_state == ST_EMIT); // R21
  wire logic next_ready = (next_state == ST_IDLE);
  // Index buffer binding: width code and offset held until rebound
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      idx_base <= '0;
      idx_wide <= NARROW_INDEX_CODE;
    end else if (i_bind_valid) begin
      idx_base <= i_bind_offset; // R3
      idx_wide <= (i_bind_width_select == WIDE_INDEX_CODE); // R17
    end
  end
  // Control and handshake flops
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      state <= ST_IDLE;
      o_cmd_ready <= 1'b0;
      o_cmd_done <= 1'b0;
      o_mem_req_valid <= 1'b0;
      o_vtx_valid <= 1'b0;
      o_restart <= 1'b0;
    end else begin
      state <= next_state;
      o_cmd_ready <= next_ready;
      o_cmd_done <= next_done;
      o_mem_req_valid <= next_req;
      o_vtx_valid <= next_valid;
      o_restart <= next_restart;
    end
  end
  // Datapath flops
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      kind <= KIND_DIRECT;
      topology <= '0;
      restart_en <= 1'b0;
      vertex_total <= WORD_RESET;
      instance_total <= WORD_RESET;
      first <= WORD_RESET;
      bias <= WORD_RESET;
      base_instance <= WORD_RESET;
      vtx_pos <= WORD_RESET;
      inst_pos <= WORD_RESET;
      cur_instance <= WORD_RESET;
      draws_left <= WORD_RESET;
      record_addr <= '0;
      stride <= '0;
      word_sel <= REC_VERTEX_TOTAL;
      o_mem_addr <= '0;
      o_emitted_vertex_number <= WORD_RESET;
      o_emitted_instance_number <= WORD_RESET;
      o_topology <= '0;
    end else begin
      kind <= next_kind;
      topology <= next_topology;
      restart_en <= next_restart_en;
      vertex_total <= next_vertex_total;
      instance_total <= next_instance_total;
      first <= next_first;
      bias <= next_bias;
      base_instance <= next_base_instance;
      vtx_pos <= next_vtx_pos;
      inst_pos <= next_inst_pos;
      cur_instance <= next_cur_instance;
      draws_left <= next_draws_left;
      record_addr <= next_record_addr;
      stride <= next_stride;
      word_sel <= next_word_sel;
      o_mem_addr <= next_mem_addr;
      o_emitted_vertex_number <= next_vertex;
      o_emitted_instance_number <= next_instance;
      o_topology <= next_topology; // R9
    end
  end

endmodule : indexed_draw_vertex_fetch

/* File: draw_fetch_pkg.sv */
// Shared constants and types for the draw vertex fetch block
package draw_fetch_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int WORD_W = 32;
  localparam int TOPO_W = 4;

  // ----------------------------------------
  // Index width codes and restart values
  // ----------------------------------------
  localparam logic NARROW_INDEX_CODE = 1'b0;
  localparam logic WIDE_INDEX_CODE = 1'b1;
  localparam logic [15:0] NARROW_RESTART = 16'hFFFF;
  localparam logic [31:0] WIDE_RESTART = 32'hFFFFFFFF;
  // Log2 of index byte width
  localparam logic [4:0] NARROW_SHIFT = 5'h01;
  localparam logic [4:0] WIDE_SHIFT = 5'h02;

  // ----------------------------------------
  // Parameter record word order
  // ----------------------------------------
  localparam logic [1:0] REC_VERTEX_TOTAL = 2'h0;
  localparam logic [1:0] REC_INSTANCE_TOTAL = 2'h1;
  localparam logic [1:0] REC_BASE_VERTEX = 2'h2;
  localparam logic [1:0] REC_BASE_INSTANCE = 2'h3;
  localparam logic [1:0] REC_LAST_WORD = 2'h3;

  // ----------------------------------------
  // Reset and increment values
  // ----------------------------------------
  localparam logic [31:0] WORD_RESET = 32'h00000000;
  localparam logic [31:0] ONE_WORD = 32'h00000001;

  // ----------------------------------------
  // Command kinds
  // ----------------------------------------
  typedef enum logic [1:0] {
    KIND_DIRECT = 2'h0,
    KIND_INDEXED = 2'h1,
    KIND_INDIRECT = 2'h2,
    KIND_UNUSED = 2'h3
  } draw_kind_t;

  // ----------------------------------------
  // Sequencer states, one-hot
  // ----------------------------------------
  typedef enum logic [8:0] {
    ST_IDLE = 9'h001,
    ST_PARAM_REQ = 9'h002,
    ST_PARAM_WAIT = 9'h004,
    ST_START = 9'h008,
    ST_VTX = 9'h010,
    ST_IDX_REQ = 9'h020,
    ST_IDX_WAIT = 9'h040,
    ST_EMIT = 9'h080,
    ST_END = 9'h100
  } fetch_state_t;

endpackage : draw_fetch_pkg

/* File: draw_fetch_props.sv */
// Port checker for the draw vertex fetch block
`timescale 1ns/100ps
module draw_fetch_props
  import draw_fetch_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_cmd_valid,
  input wire draw_fetch_pkg::draw_kind_t i_cmd_kind,
  input wire logic [draw_fetch_pkg::TOPO_W-1:0] i_cmd_topology,
  input wire logic [31:0] i_cmd_draw_total,
  input wire logic o_cmd_ready,
  input wire logic o_cmd_done,
  input wire logic o_mem_req_valid,
  input wire logic i_mem_req_ready,
  input wire logic [ADDR_W-1:0] o_mem_addr,
  input wire logic i_mem_rsp_valid,
  input wire logic o_vtx_valid,
  input wire logic i_vtx_ready,
  input wire logic [31:0] o_emitted_vertex_number,
  input wire logic [31:0] o_emitted_instance_number,
  input wire logic o_restart,
  input wire logic [draw_fetch_pkg::TOPO_W-1:0] o_topology
);
  // ----------------------------------------
  // Helper state captured per command
  // ----------------------------------------
  logic take;
  logic zero_draw, outst, seen, plain;
  logic [TOPO_W-1:0] topo;
  logic [31:0] last_inst;
  assign take = i_cmd_valid && o_cmd_ready;
  // Instance order is only monotonic within one draw, so indirect commands are left out
  always_ff @(posedge i_clk) begin
    if (i_srst) begin
      topo <= '0;
      zero_draw <= 1'b0;
      outst <= 1'b0;
      seen <= 1'b0;
      plain <= 1'b0;
      last_inst <= '0;
    end else begin
      if (take) begin
        topo <= i_cmd_topology;
        zero_draw <= (i_cmd_kind == KIND_INDIRECT) && (i_cmd_draw_total == 32'h00000000);
        plain <= i_cmd_kind != KIND_INDIRECT;
        seen <= 1'b0;
      end
      if (o_mem_req_valid && i_mem_req_ready) outst <= 1'b1;
      else if (i_mem_rsp_valid) outst <= 1'b0;
      if (o_vtx_valid && i_vtx_ready) begin
        seen <= 1'b1;
        last_inst <= o_emitted_instance_number;
      end
    end
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);
  vtx_hold_a: assert property (o_vtx_valid && !i_vtx_ready |=> o_vtx_valid && $stable(o_emitted_vertex_number)
    && $stable(o_emitted_instance_number) && $stable(o_restart)) else $error("vertex output changed while stalled");
  req_hold_a: assert property (o_mem_req_valid && !i_mem_req_ready |=> o_mem_req_valid && $stable(o_mem_addr))
    else $error("read request changed before taken");
  take_busy_a: assert property (take |=> !o_cmd_ready) else $error("ready stayed high after take");
  done_pulse_a: assert property (o_cmd_done |-> o_cmd_ready ##1 !o_cmd_done) else $error("done not one cycle");
  topo_match_a: assert property (o_vtx_valid |-> o_topology == topo) else $error("topology differs");
  inst_order_a: assert property (o_vtx_valid && seen && plain |-> o_emitted_instance_number == last_inst
    || o_emitted_instance_number == last_inst + 32'h00000001) else $error("instance order broken");
  zero_draw_a: assert property (zero_draw |-> !o_mem_req_valid && !o_vtx_valid) else $error("zero draw fetched");
  one_read_a: assert property (o_mem_req_valid |-> !outst) else $error("second read outstanding");
  idle_quiet_a: assert property (o_cmd_ready |-> !o_vtx_valid && !o_mem_req_valid) else $error("idle not quiet");
endmodule : draw_fetch_props

bind indexed_draw_vertex_fetch draw_fetch_props #(.ADDR_W(ADDR_W)) props (.i_clk, .i_srst, .i_cmd_valid,
  .i_cmd_kind, .i_cmd_topology, .i_cmd_draw_total, .o_cmd_ready, .o_cmd_done, .o_mem_req_valid, .i_mem_req_ready,
  .o_mem_addr, .i_mem_rsp_valid, .o_vtx_valid, .i_vtx_ready, .o_emitted_vertex_number, .o_emitted_instance_number,
  .o_restart, .o_topology);

/* File: mem_partner.sv */
// Memory model holding index buffers and parameter records
`timescale 1ns/100ps
module mem_partner (
  input wire logic i_clk,
  input wire logic i_srst,
  input wire logic i_slow,
  input wire logic i_req_valid,
  output logic o_req_ready,
  input wire logic [31:0] i_addr,
  output logic o_rsp_valid,
  output logic [31:0] o_rsp_data
);
  logic [31:0] mem [0:63];
  logic [31:0] log_q [$];
  logic [31:0] addr;
  logic pend;
  int cnt;
  initial begin
    o_req_ready = 1'b0;
    o_rsp_valid = 1'b0;
    o_rsp_data = 32'h00000000;
    pend = 1'b0;
  end
  // One read in flight; slow mode toggles ready and delays the answer
  always @(posedge i_clk) begin
    o_rsp_valid <= 1'b0;
    o_rsp_data <= ~o_rsp_data; // Data outside a response is the previous cycle's word inverted
    if (i_srst) begin
      o_req_ready <= 1'b0;
      pend <= 1'b0;
    end else if (i_req_valid && o_req_ready) begin
      o_req_ready <= 1'b0;
      pend <= 1'b1;
      addr <= i_addr;
      cnt <= i_slow ? 3 : 0;
      log_q.push_back(i_addr);
    end else if (pend) begin
      if (cnt == 0) begin
        pend <= 1'b0;
        o_rsp_valid <= 1'b1;
        o_rsp_data <= mem[addr[7:2]]; // Aligned word that holds the addressed byte
      end else begin
        cnt <= cnt - 1;
      end
    end else begin
      o_req_ready <= !i_slow || !o_req_ready;
    end
  end
endmodule : mem_partner

/* File: tb.sv */
// Self-checking bench for the draw vertex fetch block
`timescale 1ns/100ps
module tb;
  import draw_fetch_pkg::*;
  logic i_clk, i_srst, i_bind_valid, i_bind_width_select, i_cmd_valid, i_cmd_restart_enable;
  draw_kind_t i_cmd_kind;
  logic [3:0] i_cmd_topology, o_topology;
  logic [31:0] i_bind_offset, i_cmd_vertex_total, i_cmd_instance_total, i_cmd_start_slot;
  logic [31:0] i_cmd_base_vertex_number, i_cmd_index_bias, i_cmd_base_instance_id;
  logic [31:0] i_cmd_param_offset, i_cmd_draw_total, i_cmd_stride, o_mem_addr, i_mem_rsp_data;
  logic [31:0] o_emitted_vertex_number, o_emitted_instance_number;
  logic o_cmd_ready, o_cmd_done, o_mem_req_valid, i_mem_req_ready, i_mem_rsp_valid;
  logic o_vtx_valid, i_vtx_ready, o_restart, slow, stall;
  logic [31:0] ev [$], ei [$], ea [$], gv [$], gi [$];
  logic er [$], gr [$];
  int errors, total_checks;

  indexed_draw_vertex_fetch #(.ADDR_W(32)) uut (.i_clk, .i_srst, .i_bind_valid, .i_bind_offset,
    .i_bind_width_select, .i_cmd_valid, .o_cmd_ready, .i_cmd_kind, .i_cmd_topology, .i_cmd_restart_enable,
    .i_cmd_vertex_total, .i_cmd_instance_total, .i_cmd_start_slot, .i_cmd_base_vertex_number,
    .i_cmd_index_bias, .i_cmd_base_instance_id, .i_cmd_param_offset, .i_cmd_draw_total, .i_cmd_stride,
    .o_cmd_done, .o_mem_req_valid, .i_mem_req_ready, .o_mem_addr, .i_mem_rsp_valid, .i_mem_rsp_data,
    .o_vtx_valid, .i_vtx_ready, .o_emitted_vertex_number, .o_emitted_instance_number, .o_restart, .o_topology);
  mem_partner mdl (.i_clk(i_clk), .i_srst(i_srst), .i_slow(slow), .i_req_valid(o_mem_req_valid),
    .o_req_ready(i_mem_req_ready), .i_addr(o_mem_addr), .o_rsp_valid(i_mem_rsp_valid), .o_rsp_data(i_mem_rsp_data));

  // ----------------------------------------
  // Clock, downstream sink, watchdog
  // ----------------------------------------
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // Sink stalls every other cycle when asked, so held outputs get exercised
  always @(posedge i_clk) begin
    i_vtx_ready <= !stall || !i_vtx_ready;
    if (o_vtx_valid && i_vtx_ready) begin
      gv.push_back(o_emitted_vertex_number);
      gi.push_back(o_emitted_instance_number);
      gr.push_back(o_restart);
    end
  end
  initial begin
    repeat (20000) @(posedge i_clk);
    errors++;
    give_verdict();
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(string s, logic [31:0] e, logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      $display("unexpected %s: expected %h seen %h", s, e, g);
      errors++;
    end
  endtask : chk
  task automatic ex(logic [31:0] v, logic [31:0] i, logic r);
    ev.push_back(v);
    ei.push_back(i);
    er.push_back(r);
  endtask : ex
  task automatic bind_buf(logic [31:0] off, logic w);
    @(posedge i_clk);
    i_bind_valid <= 1'b1;
    i_bind_offset <= off;
    i_bind_width_select <= w;
    @(posedge i_clk);
    i_bind_valid <= 1'b0;
  endtask : bind_buf
  // Offers the prepared command, waits for done and compares the whole stream
  task automatic run();
    int n;
    n = 0;
    gv.delete();
    gi.delete();
    gr.delete();
    mdl.log_q.delete();
    do @(negedge i_clk); while (o_cmd_ready !== 1'b1 && ++n < 100);
    @(posedge i_clk);
    i_cmd_valid <= 1'b1;
    @(posedge i_clk);
    i_cmd_valid <= 1'b0;
    n = 0;
    do @(negedge i_clk); while (o_cmd_done !== 1'b1 && ++n < 4000);
    chk("done", 1, o_cmd_done);
    chk("vertex count", ev.size(), gv.size());
    foreach (gv[k]) if (k < ev.size()) begin
      chk("vertex", ev[k], gv[k]);
      chk("instance", ei[k], gi[k]);
      chk("restart", er[k], gr[k]);
    end
    chk("fetch count", 1, ea.size() == 0 ? mdl.log_q.size() == 0 : mdl.log_q.size() >= ea.size());
    foreach (mdl.log_q[k]) if (ea.size() > 0) chk("address", ea[k % ea.size()], mdl.log_q[k]);
    ev.delete();
    ei.delete();
    er.delete();
    ea.delete();
  endtask : run

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_direct();
    @(posedge i_clk);
    i_cmd_kind <= KIND_DIRECT;
    i_cmd_vertex_total <= 32'h3;
    i_cmd_instance_total <= 32'h2;
    i_cmd_base_vertex_number <= 32'hFFFFFFFE;
    i_cmd_base_instance_id <= 32'h7;
    stall <= 1'b1;
    for (int i = 0; i < 2; i++) for (int v = 0; v < 3; v++) ex(32'hFFFFFFFE + v, 32'h7 + i, 1'b0);
    run();
  endtask : t_direct
  task automatic t_narrow();
    mdl.mem[4] = 32'h00041234;
    mdl.mem[5] = 32'h8000FFFF;
    bind_buf(32'h10, NARROW_INDEX_CODE);
    i_cmd_kind <= KIND_INDEXED;
    i_cmd_topology <= 4'h5;
    i_cmd_start_slot <= 32'h1;
    i_cmd_vertex_total <= 32'h3;
    i_cmd_instance_total <= 32'h1;
    i_cmd_index_bias <= 32'hFFFFFFFE;
    i_cmd_base_instance_id <= 32'h0;
    i_cmd_restart_enable <= 1'b1;
    slow <= 1'b1;
    ex(32'h2, 32'h0, 1'b0);
    ex(32'hFFFD, 32'h0, 1'b1);
    ex(32'h7FFE, 32'h0, 1'b0);
    for (int k = 0; k < 3; k++) ea.push_back(32'h12 + 2 * k);
    run();
  endtask : t_narrow
  task automatic t_wide();
    mdl.mem[9] = 32'hFFFFFFFF;
    mdl.mem[10] = 32'h00000010;
    bind_buf(32'h20, WIDE_INDEX_CODE);
    i_cmd_vertex_total <= 32'h2;
    i_cmd_instance_total <= 32'h2;
    i_cmd_index_bias <= 32'h1;
    i_cmd_base_instance_id <= 32'h3;
    i_cmd_restart_enable <= 1'b0;
    slow <= 1'b0;
    for (int i = 0; i < 2; i++) for (int v = 0; v < 2; v++) ex(v ? 32'h11 : 32'h0, 32'h3 + i, 1'b0);
    ea.push_back(32'h24);
    ea.push_back(32'h28);
    run();
  endtask : t_wide
  task automatic t_ind(logic [31:0] tot, logic [31:0] off, logic [31:0] str);
    @(posedge i_clk);
    i_cmd_kind <= KIND_INDIRECT;
    i_cmd_draw_total <= tot;
    i_cmd_param_offset <= off;
    i_cmd_stride <= str;
    run();
  endtask : t_ind
  task automatic t_indirect();
    for (int w = 0; w < 4; w++) mdl.mem[16 + w] = w == 0 ? 32'h2 : w == 1 ? 32'h1 : w == 2 ? 32'h9 : 32'h4;
    for (int w = 0; w < 4; w++) mdl.mem[24 + w] = w == 0 ? 32'h1 : w == 1 ? 32'h2 : w == 2 ? 32'h100 : 32'h0;
    slow <= 1'b1;
    ex(32'h9, 32'h4, 1'b0);
    ex(32'hA, 32'h4, 1'b0);
    ex(32'h100, 32'h0, 1'b0);
    ex(32'h100, 32'h1, 1'b0);
    for (int k = 0; k < 8; k++) ea.push_back((k < 4 ? 32'h40 : 32'h60) + 4 * (k % 4));
    t_ind(32'h2, 32'h40, 32'h20);
    ex(32'h100, 32'h0, 1'b0);
    ex(32'h100, 32'h1, 1'b0);
    for (int k = 0; k < 4; k++) ea.push_back(32'h60 + 4 * k);
    t_ind(32'h1, 32'h60, 32'h5);
    t_ind(32'h0, 32'h40, 32'h20);
    @(posedge i_clk);
    i_cmd_kind <= KIND_UNUSED;
    run();
  endtask : t_indirect

  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : give_verdict

  // Reset, then the scenarios in turn
  initial begin
    {i_srst, slow, stall, i_bind_valid, i_bind_width_select, i_cmd_valid, i_cmd_restart_enable} = 7'h40;
    {i_bind_offset, i_cmd_vertex_total, i_cmd_instance_total, i_cmd_start_slot} = '0;
    {i_cmd_base_vertex_number, i_cmd_index_bias, i_cmd_base_instance_id} = '0;
    {i_cmd_param_offset, i_cmd_draw_total, i_cmd_stride, i_cmd_topology} = '0;
    i_cmd_kind = KIND_DIRECT;
    i_vtx_ready = 1'b0;
    errors = 0;
    total_checks = 0;
    repeat (12) @(posedge i_clk);
    i_srst <= 1'b0;
    t_direct();
    t_narrow();
    t_wide();
    t_indirect();
    give_verdict();
  end
endmodule : tb
